// ===== rtl/ext_data_access_stretch_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - stretch is clock control bits 2..0 at 8Eh
// - stretch 0: two cycles, strobe 2 clocks
// - stretch 7: nine cycles, strobe 28 clocks
// - stretch 1..6: n+2 cycles, strobe 4n clocks
// - stretch resets to 1, three cycle moves
// - program fetch always one 4-clock cycle
// - stretch rewrites govern later data moves
// - low address/data multiplexed, high address separate
// - two 16-bit pointers at 82h..85h
// - select is lsb of 86h, rest zero
// - moves and increments use selected pointer
// - rate bit set 4 clocks, clear 12
// - bits 5,4,3 pick timers 2,1,0
// - each machine cycle: four clocks, one latch
module ext_data_access_stretch_ctrl (
  input  wire logic                 REF_CLK_IN,       // system clock
  input  wire logic                 NRST_IN,          // async reset
  input  wire logic                 SFR_WR_IN,        // register write
  input  wire logic                 SFR_RD_IN,        // register read
  input  wire logic [7:0]           SFR_ADDR_IN,      // register address
  input  wire logic [7:0]           SFR_WDATA_IN,     // write data
  output var  logic [7:0]           SFR_RDATA_OUT,    // read data
  input  wire logic                 XMOVE_REQ_IN,     // start data move
  input  wire logic                 XMOVE_WRITE_IN,   // move is a write
  input  wire logic [7:0]           XMOVE_WDATA_IN,   // move write data
  input  wire logic                 PTR_INC_IN,       // bump pointer
  input  wire logic                 FETCH_REQ_IN,     // start fetch
  input  wire logic [15:0]          FETCH_ADDR_IN,    // fetch address
  output var  logic                 BUSY_OUT,         // access running
  output var  logic                 XMOVE_DONE_OUT,   // move finished
  output var  logic [7:0]           XMOVE_RDATA_OUT,  // move read data
  output var  logic                 FETCH_DONE_OUT,   // fetch finished
  output var  logic [7:0]           FETCH_DATA_OUT,   // fetched byte
  input  wire logic [7:0]           LO_PORT_IN,       // low port level
  output var  xstretch_pkg::ext_bus_s EXT_BUS_OUT,    // bus pins
  output var  logic [2:0]           TMR_TICK_OUT      // timer counts
);
  import xstretch_pkg::*;

  // ======================================================
  // state
  typedef struct packed {
    bus_state_e  st;
    logic [5:0]  clk_ctrl;
    logic [1:0]  phase;
    logic [3:0]  cyc;
    logic [3:0]  last_cyc;
    logic [4:0]  strb_w;
    logic [4:0]  strb_cnt;
    logic        write;
    logic [7:0]  wdata;
    logic [15:0] addr;
    ext_bus_s    bus;
    logic [7:0]  sfr_rdata;
    logic        xdone;
    logic [7:0]  xrdata;
    logic        fdone;
    logic [7:0]  fdata;
    logic        busy;
  } ctrl_state_s;

  localparam ctrl_state_s RESET_STATE = '{
    st:        ST_IDLE,
    clk_ctrl:  CLK_CTRL_RESET,
    phase:     2'h0,
    cyc:       4'h0,
    last_cyc:  4'h0,
    strb_w:    5'h00,
    strb_cnt:  5'h00,
    write:     1'b0,
    wdata:     8'h00,
    addr:      16'h0000,
    bus:       '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                 psen_n: 1'b1, lo_out: 8'h00,
                 lo_oe: 1'b0, hi_out: 8'h00},
    sfr_rdata: 8'h00,
    xdone:     1'b0,
    xrdata:    8'h00,
    fdone:     1'b0,
    fdata:     8'h00,
    busy:      1'b0
  };

  ctrl_state_s s;
  ctrl_state_s next_s;
  sfr_wr_s     sfr_wr;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic [15:0] act_ptr;
  logic        ptr_sel;

  // strobe length in clocks for a stretch value
  function automatic logic [4:0] strobe_clocks(input logic [2:0] sv);
    if (sv == 3'h0) begin
      strobe_clocks = STRB_ZERO_CLKS;
    end else begin
      strobe_clocks = 5'({2'b00, sv} * MC_CLOCKS);
    end
  endfunction : strobe_clocks

  // ======================================================
  // pointer pair and timer rate helpers
  assign sfr_wr = '{wr: SFR_WR_IN, addr: SFR_ADDR_IN,
                    data: SFR_WDATA_IN};

  xptr_bank u_ptr (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (NRST_IN),
    .sfr_in   (sfr_wr),
    .inc_in   (PTR_INC_IN),
    .p0_out   (ptr0),
    .p1_out   (ptr1),
    .act_out  (act_ptr),
    .sel_out  (ptr_sel)
  );

  tmr_rate_gen u_rate (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (NRST_IN),
    .fast_in  (s.clk_ctrl[TMR2_RATE_BIT:TMR0_RATE_BIT]),
    .tick_out (TMR_TICK_OUT)
  );

  // ======================================================
  // register access, access sequencer and pin values
  always_comb begin
    next_s = s;
    next_s.xdone = 1'b0;
    next_s.fdone = 1'b0;
    // control register write, top two bits dropped
    if (SFR_WR_IN && SFR_ADDR_IN == ADDR_CLK_CTRL) begin
      next_s.clk_ctrl = SFR_WDATA_IN[5:0];
    end
    // register read, unmapped addresses read zero
    if (SFR_RD_IN) begin
      case (SFR_ADDR_IN)
        ADDR_PTR0_LO:  next_s.sfr_rdata = ptr0[7:0];
        ADDR_PTR0_HI:  next_s.sfr_rdata = ptr0[15:8];
        ADDR_PTR1_LO:  next_s.sfr_rdata = ptr1[7:0];
        ADDR_PTR1_HI:  next_s.sfr_rdata = ptr1[15:8];
        ADDR_PTR_SEL:  next_s.sfr_rdata = {7'h00, ptr_sel};
        ADDR_CLK_CTRL: next_s.sfr_rdata = {2'b00, s.clk_ctrl};
        default:       next_s.sfr_rdata = 8'h00;
      endcase
    end
    // sequencer
    unique case (s.st)
      ST_IDLE: begin
        if (XMOVE_REQ_IN) begin
          next_s.st = ST_XMOVE;
          next_s.phase = 2'h0;
          next_s.cyc = 4'h0;
          // stretch captured here, later rewrites wait
          next_s.last_cyc = {1'b0, s.clk_ctrl[STRETCH_MSB:0]}
                            + BASE_CYCLES - 4'h1;
          next_s.strb_w = strobe_clocks(s.clk_ctrl[STRETCH_MSB:0]);
          next_s.write = XMOVE_WRITE_IN;
          next_s.wdata = XMOVE_WDATA_IN;
          next_s.addr = act_ptr;
        end else if (FETCH_REQ_IN) begin
          next_s.st = ST_FETCH;
          next_s.phase = 2'h0;
          next_s.cyc = 4'h0;
          next_s.addr = FETCH_ADDR_IN;
        end
      end
      ST_FETCH: begin
        // fixed single machine cycle, stretch ignored
        next_s.phase = s.phase + 2'h1;
        if (s.phase == FETCH_RD_PHASE) begin
          next_s.fdata = LO_PORT_IN;
        end
        if (s.phase == LAST_PHASE) begin
          next_s.st = ST_IDLE;
          next_s.fdone = 1'b1;
        end
      end
      ST_XMOVE: begin
        next_s.phase = s.phase + 2'h1;
        if (s.phase == LAST_PHASE) begin
          if (s.cyc == s.last_cyc) begin
            next_s.st = ST_IDLE;
            next_s.xdone = 1'b1;
          end else begin
            next_s.cyc = s.cyc + 4'h1;
          end
        end
        // strobe opens one clock into the second cycle
        if (s.cyc == STRB_LOAD_CYC && s.phase == 2'h0) begin
          next_s.strb_cnt = s.strb_w;
        end else if (s.strb_cnt != 5'h00) begin
          next_s.strb_cnt = s.strb_cnt - 5'h01;
        end
        // read data taken on the last strobe clock
        if (!s.write && s.strb_cnt == 5'h01) begin
          next_s.xrdata = LO_PORT_IN;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    // pin values follow the next position
    next_s.busy = (next_s.st != ST_IDLE);
    next_s.bus.ale = next_s.busy && next_s.phase == 2'h0;
    next_s.bus.psen_n = !(next_s.st == ST_FETCH &&
                          next_s.phase inside {2'h1, 2'h2});
    next_s.bus.rd_n = !(next_s.st == ST_XMOVE && !next_s.write &&
                        next_s.strb_cnt != 5'h00);
    next_s.bus.wr_n = !(next_s.st == ST_XMOVE && next_s.write &&
                        next_s.strb_cnt != 5'h00);
    if ((next_s.st == ST_FETCH && next_s.phase == 2'h0) ||
        (next_s.st == ST_XMOVE && next_s.cyc == 4'h0)) begin
      next_s.bus.lo_out = next_s.addr[7:0];
      next_s.bus.lo_oe = 1'b1;
    end else if (next_s.st == ST_XMOVE && next_s.write) begin
      next_s.bus.lo_out = next_s.wdata;
      next_s.bus.lo_oe = 1'b1;
    end else begin
      next_s.bus.lo_oe = 1'b0;
    end
    if (next_s.busy) begin
      next_s.bus.hi_out = next_s.addr[15:8];
    end
  end

  // state register
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign SFR_RDATA_OUT   = s.sfr_rdata;
  assign BUSY_OUT        = s.busy;
  assign XMOVE_DONE_OUT  = s.xdone;
  assign XMOVE_RDATA_OUT = s.xrdata;
  assign FETCH_DONE_OUT  = s.fdone;
  assign FETCH_DATA_OUT  = s.fdata;
  assign EXT_BUS_OUT     = s.bus;

  // ======================================================
  // check helpers: stretch at start, move and strobe lengths
  logic [2:0] ast_stretch;
  logic [5:0] ast_op_len;
  logic [4:0] ast_strb_len;

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ast_stretch <= 3'h0;
      ast_op_len <= 6'h00;
      ast_strb_len <= 5'h00;
    end else begin
      if (s.st == ST_IDLE && XMOVE_REQ_IN) begin
        ast_stretch <= s.clk_ctrl[STRETCH_MSB:0];
        ast_op_len <= 6'h00;
      end else if (s.st == ST_XMOVE) begin
        ast_op_len <= ast_op_len + 6'h01;
      end
      if (!s.bus.rd_n || !s.bus.wr_n) begin
        ast_strb_len <= ast_strb_len + 5'h01;
      end else begin
        ast_strb_len <= 5'h00;
      end
    end
  end

  default clocking ast_cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  // ======================================================
  // checks
  AST_XMOVE_LEN: assert property (
    s.xdone |-> ast_op_len ==
      6'(({3'h0, ast_stretch} + 6'h02) * 6'h04))
    else $error("data move length does not match stretch");

  AST_STRB_WIDTH: assert property (
    $rose(s.bus.rd_n & s.bus.wr_n) |->
      ast_strb_len == strobe_clocks(ast_stretch))
    else $error("strobe width does not match stretch");

  AST_STRETCH_RESET: assert property (
    !$past(NRST_IN) |-> s.clk_ctrl == CLK_CTRL_RESET)
    else $error("control register reset value wrong");

  AST_FETCH_PSEN: assert property (
    $fell(s.bus.psen_n) |=> !s.bus.psen_n ##1 s.bus.psen_n ##1
      !s.busy)
    else $error("fetch strobe not two clocks in one cycle");

  // a fetch ends after one machine cycle whatever the stretch holds
  AST_FETCH_FIXED: assert property (
    s.st == ST_IDLE && FETCH_REQ_IN && !XMOVE_REQ_IN |->
      ##5 s.fdone)
    else $error("fetch length not fixed at one cycle");

  AST_CTRL_WRITE: assert property (
    SFR_WR_IN && SFR_ADDR_IN == ADDR_CLK_CTRL |=>
      s.clk_ctrl == 6'($past(SFR_WDATA_IN)))
    else $error("control register write lost");

  AST_LOW_ADDR: assert property (
    s.st == ST_XMOVE && s.cyc == 4'h0 |->
      s.bus.lo_oe && {s.bus.hi_out, s.bus.lo_out} == s.addr)
    else $error("address not on the ports in first cycle");

  AST_HIGH_HOLD: assert property (
    s.st == ST_XMOVE |-> s.bus.hi_out == s.addr[15:8])
    else $error("high address port moved during access");

  AST_SEL_READ: assert property (
    SFR_RD_IN && SFR_ADDR_IN == ADDR_PTR_SEL |=>
      SFR_RDATA_OUT == {7'h00, $past(ptr_sel)})
    else $error("select register read wrong");

  AST_PTR_USED: assert property (
    s.st == ST_IDLE && XMOVE_REQ_IN |=> s.addr == $past(act_ptr))
    else $error("data move did not use selected pointer");

  AST_ALE_GAP: assert property (
    s.bus.ale |=> !s.bus.ale [*3])
    else $error("latch strobe more than once per cycle");

  // the next latch strobe follows four clocks on, unless the access ended
  AST_ALE_EACH: assert property (
    s.bus.ale |-> ##4 (s.bus.ale || !s.busy))
    else $error("machine cycle without latch strobe");

  AST_CTRL_READ: assert property (
    SFR_RD_IN && SFR_ADDR_IN == ADDR_CLK_CTRL |=>
      SFR_RDATA_OUT == {2'b00, $past(s.clk_ctrl)})
    else $error("control register read wrong");

endmodule : ext_data_access_stretch_ctrl
`default_nettype wire

// ===== rtl/xstretch_pkg.sv
package xstretch_pkg;
  // ======================================================
  // register addresses
  localparam logic [7:0]  ADDR_PTR0_LO   = 8'h82;
  localparam logic [7:0]  ADDR_PTR0_HI   = 8'h83;
  localparam logic [7:0]  ADDR_PTR1_LO   = 8'h84;
  localparam logic [7:0]  ADDR_PTR1_HI   = 8'h85;
  localparam logic [7:0]  ADDR_PTR_SEL   = 8'h86;
  localparam logic [7:0]  ADDR_CLK_CTRL  = 8'h8e;
  // ======================================================
  // field positions and values after reset
  localparam int          STRETCH_MSB    = 2;
  localparam int          TMR0_RATE_BIT  = 3;
  localparam int          TMR2_RATE_BIT  = 5;
  localparam int          PTR_SEL_BIT    = 0;
  localparam logic [5:0]  CLK_CTRL_RESET = 6'h01;
  localparam logic        PTR_SEL_RESET  = 1'b0;
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  // ======================================================
  // cycle counts
  localparam logic [1:0]  LAST_PHASE     = 2'h3;
  localparam logic [1:0]  FETCH_RD_PHASE = 2'h2;
  localparam logic [3:0]  STRB_LOAD_CYC  = 4'h1;
  localparam logic [3:0]  BASE_CYCLES    = 4'h2;
  localparam logic [4:0]  MC_CLOCKS      = 5'h04;
  localparam logic [4:0]  STRB_ZERO_CLKS = 5'h02;
  localparam logic [3:0]  TMR_FAST_CLKS  = 4'h4;
  localparam logic [3:0]  TMR_SLOW_CLKS  = 4'hc;
  localparam int          TIMER_COUNT    = 3;
  // ======================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_XMOVE = 2'b10
  } bus_state_e;
  typedef struct packed {
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       psen_n;
    logic [7:0] lo_out;
    logic       lo_oe;
    logic [7:0] hi_out;
  } ext_bus_s;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } sfr_wr_s;
endpackage : xstretch_pkg

// ===== rtl/xptr_bank.sv
`timescale 1ns/100ps
`default_nettype none
module xptr_bank (
  input  wire logic                   clk_in,   // system clock
  input  wire logic                   rst_n_in, // async reset
  input  wire xstretch_pkg::sfr_wr_s  sfr_in,   // register write
  input  wire logic                   inc_in,   // bump active pointer
  output var  logic [15:0]            p0_out,   // first pointer
  output var  logic [15:0]            p1_out,   // second pointer
  output var  logic [15:0]            act_out,  // selected pointer
  output var  logic                   sel_out   // select bit
);
  import xstretch_pkg::*;
  typedef struct packed {
    logic [1:0][15:0] ptr;
    logic             sel;
  } ptr_state_s;
  ptr_state_s s;
  ptr_state_s next_s;
  // ======================================================
  // increment, then byte writes override
  always_comb begin
    next_s = s;
    if (inc_in) begin
      next_s.ptr[s.sel] = s.ptr[s.sel] + 16'h0001;
    end
    if (sfr_in.wr) begin
      case (sfr_in.addr)
        ADDR_PTR0_LO: next_s.ptr[0][7:0] = sfr_in.data;
        ADDR_PTR0_HI: next_s.ptr[0][15:8] = sfr_in.data;
        ADDR_PTR1_LO: next_s.ptr[1][7:0] = sfr_in.data;
        ADDR_PTR1_HI: next_s.ptr[1][15:8] = sfr_in.data;
        ADDR_PTR_SEL: next_s.sel = sfr_in.data[PTR_SEL_BIT];
        default: next_s.sel = s.sel;
      endcase
    end
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= {PTR_RESET, PTR_RESET, PTR_SEL_RESET};
    end else begin
      s <= next_s;
    end
  end
  assign p0_out  = s.ptr[0];
  assign p1_out  = s.ptr[1];
  assign sel_out = s.sel;
  assign act_out = s.sel ? s.ptr[1] : s.ptr[0];
  // ======================================================
  // checks
  AST_PTR_INC: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    inc_in && !sfr_in.wr |=> act_out == $past(act_out) + 16'h0001)
    else $error("selected pointer did not advance");
endmodule : xptr_bank
`default_nettype wire

// ===== rtl/tmr_rate_gen.sv
`timescale 1ns/100ps
`default_nettype none
module tmr_rate_gen (
  input  wire logic       clk_in,   // system clock
  input  wire logic       rst_n_in, // async reset
  input  wire logic [2:0] fast_in,  // per timer 4-clock rate
  output var  logic [2:0] tick_out  // per timer count pulse
);
  import xstretch_pkg::*;
  typedef struct packed {
    logic [2:0][3:0] cnt;
    logic [2:0]      tick;
  } rate_state_s;
  rate_state_s s;
  rate_state_s next_s;
  // ======================================================
  // one prescaler per timer, each with its own rate
  always_comb begin
    logic [3:0] lim;
    lim = TMR_SLOW_CLKS;
    next_s = s;
    for (int i = 0; i < TIMER_COUNT; i++) begin
      lim = fast_in[i] ? TMR_FAST_CLKS : TMR_SLOW_CLKS;
      if (s.cnt[i] >= lim - 4'h1) begin
        next_s.cnt[i] = 4'h0;
        next_s.tick[i] = 1'b1;
      end else begin
        next_s.cnt[i] = s.cnt[i] + 4'h1;
        next_s.tick[i] = 1'b0;
      end
    end
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign tick_out = s.tick;
  // ======================================================
  // checks
  genvar g;
  for (g = 0; g < TIMER_COUNT; g++) begin : g_ast
    AST_TICK_FAST: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s.tick[g] ##0 fast_in[g] [*4] |=> s.tick[g])
      else $error("fast timer tick not every 4 clocks");
    AST_TICK_SLOW: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s.tick[g] ##0 !fast_in[g] [*8] |-> !s.tick[g])
      else $error("slow timer tick came too early");
  end
endmodule : tmr_rate_gen
`default_nettype wire

// ===== bench/xbus_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// external ram and code memory on the multiplexed bus
module xbus_ram_model #(
  parameter int READY_CLKS = 0 // strobe clocks before data is valid
) (
  input  wire logic                   clk_in,     // system clock
  input  wire logic                   rst_n_in,   // async reset
  input  wire xstretch_pkg::ext_bus_s bus_in,     // device pins
  output var  logic [7:0]             lo_port_out // low port level
);
  import xstretch_pkg::*;
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic        held;
  logic        strb_q;
  logic [7:0]  last;
  int          cnt;
  wire logic   strb = !bus_in.rd_n || !bus_in.wr_n || !bus_in.psen_n;
  // drive read data, else mirror the device, else a changing pattern
  always_comb begin
    if (!bus_in.rd_n && cnt >= READY_CLKS)
      lo_port_out = mem[addr];
    else if (!bus_in.psen_n && cnt >= READY_CLKS)
      lo_port_out = addr[7:0] ^ addr[15:8] ^ 8'h5a;
    else if (bus_in.lo_oe)
      lo_port_out = bus_in.lo_out;
    else
      lo_port_out = ~last;
  end
  // latch the address on the first latch pulse of an access
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr   <= 16'h0000;
      held   <= 1'b0;
      strb_q <= 1'b0;
      last   <= 8'h00;
      cnt    <= 0;
    end else begin
      last   <= lo_port_out;
      strb_q <= strb;
      cnt    <= strb ? cnt + 1 : 0;
      if (bus_in.ale && !held) begin
        addr <= {bus_in.hi_out, bus_in.lo_out};
        held <= 1'b1;
      end
      if (strb_q && !strb)
        held <= 1'b0;
    end
  end
  // store write data while the write strobe is low
  always_ff @(posedge clk_in)
    if (!bus_in.wr_n)
      mem[addr] <= bus_in.lo_out;
endmodule : xbus_ram_model
`default_nettype wire

// ===== bench/tb_ext_data_access_stretch_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ext_data_access_stretch_ctrl;
  import xstretch_pkg::*;
  logic       clk = 1'b0, nrst = 1'b0;
  logic       sfr_wr = 1'b0, sfr_rd = 1'b0, req = 1'b0, wr = 1'b0;
  logic       inc = 1'b0, freq = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, mdata = 8'h00, rdata, lo_port;
  logic [7:0] mrdata, fdata, d;
  logic [15:0] faddr = 16'h0000;
  logic       busy, mdone, fdone;
  logic [2:0] tick;
  ext_bus_s   bus;
  int         err_count = 0, checks = 0;
  // ======================================================
  // clock, design and bus partner
  always #20 clk = ~clk;
  ext_data_access_stretch_ctrl ext_data_access_stretch_ctrl_i (
    .REF_CLK_IN(clk), .NRST_IN(nrst), .SFR_WR_IN(sfr_wr),
    .SFR_RD_IN(sfr_rd), .SFR_ADDR_IN(addr), .SFR_WDATA_IN(wdata),
    .SFR_RDATA_OUT(rdata), .XMOVE_REQ_IN(req), .XMOVE_WRITE_IN(wr),
    .XMOVE_WDATA_IN(mdata), .PTR_INC_IN(inc), .FETCH_REQ_IN(freq),
    .FETCH_ADDR_IN(faddr), .BUSY_OUT(busy), .XMOVE_DONE_OUT(mdone),
    .XMOVE_RDATA_OUT(mrdata), .FETCH_DONE_OUT(fdone),
    .FETCH_DATA_OUT(fdata), .LO_PORT_IN(lo_port), .EXT_BUS_OUT(bus),
    .TMR_TICK_OUT(tick));
  xbus_ram_model xbus_ram_model_i (
    .clk_in(clk), .rst_n_in(nrst), .bus_in(bus), .lo_port_out(lo_port));
  // ======================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk); #1;
    addr = a; wdata = v; sfr_wr = 1'b1;
    @(posedge clk); #1;
    sfr_wr = 1'b0;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk); #1;
    addr = a; sfr_rd = 1'b1;
    @(posedge clk); #1;
    sfr_rd = 1'b0;
    v = rdata;
  endtask : sfr_read
  // one access: count busy clocks, latch pulses and strobe clocks
  task automatic access(input logic fetch, input logic w,
                        input logic [7:0] v, input logic [2:0] s,
                        input logic [15:0] a, output logic [7:0] r);
    int nb, na, ns, k;
    logic [15:0] sa;
    nb = 0; na = 0; ns = 0; sa = 16'h0000;
    @(posedge clk); #1;
    wr = w; mdata = v; faddr = a;
    if (fetch) freq = 1'b1; else req = 1'b1;
    @(posedge clk); #1;
    req = 1'b0; freq = 1'b0;
    for (k = 0; k < 80 && (fetch ? fdone : mdone) !== 1'b1; k++) begin
      if (busy === 1'b1) nb++;
      if (bus.ale === 1'b1) begin
        na++;
        if (na == 1) sa = {bus.hi_out, bus.lo_out};
      end
      if ((fetch ? bus.psen_n : w ? bus.wr_n : bus.rd_n) === 1'b0) ns++;
      @(posedge clk); #1;
    end
    r = fetch ? fdata : mrdata;
    check("done seen", 16'(k < 80), 16'h0001);
    check("address", sa, a);
    if (fetch) begin
      check("fetch busy clocks", 16'(nb), 16'h0004);
      check("fetch latch pulses", 16'(na), 16'h0001);
      check("fetch strobe clocks", 16'(ns), 16'h0002);
    end else begin
      check("busy clocks", 16'(nb), 16'(4 * (s + 2)));
      check("latch pulses", 16'(na), 16'(s + 2));
      check("strobe clocks", 16'(ns),
            s == 3'h0 ? 16'h0002 : 16'(4 * s));
    end
  endtask : access
  // clocks between two ticks of one timer
  task automatic tick_gap(input int idx, input int exp);
    int n, k;
    for (k = 0; k < 40 && tick[idx] !== 1'b1; k++) begin
      @(posedge clk); #1;
    end
    n = 0;
    do begin
      @(posedge clk); #1;
      n++;
    end while (tick[idx] !== 1'b1 && n < 40);
    check("timer gap", 16'(n), 16'(exp));
  endtask : tick_gap
  // ======================================================
  // watchdog
  initial begin
    #(8000 * 40);
    err_count++;
    conclude();
  end
  // ======================================================
  // tests
  initial begin
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    sfr_read(ADDR_CLK_CTRL, d);
    check("control reset", d, 8'h01);
    sfr_read(ADDR_PTR_SEL, d);
    check("select reset", d, 8'h00);
    for (int j = 0; j < 3; j++) tick_gap(j, 12);
    access(1'b0, 1'b1, 8'h5e, 3'h1, 16'h0000, d);
    sfr_read(8'h81, d);
    check("unmapped read", d, 8'h00);
    sfr_write(ADDR_CLK_CTRL, 8'hff);
    sfr_read(ADDR_CLK_CTRL, d);
    check("control bits", d, 8'h3f);
    for (int i = 0; i < 3; i++) begin
      sfr_write(ADDR_CLK_CTRL, 8'h08 << i);
      for (int j = 0; j < 3; j++)
        tick_gap(j, i == j ? 4 : 12);
    end
    for (int s = 0; s < 8; s++) begin
      sfr_write(ADDR_CLK_CTRL, 8'(s));
      sfr_write(ADDR_PTR0_LO, 8'(s * 16 + 1));
      sfr_write(ADDR_PTR0_HI, 8'ha0 + 8'(s));
      access(1'b0, 1'b1, 8'h3c ^ 8'(s), 3'(s),
             {8'ha0 + 8'(s), 8'(s * 16 + 1)}, d);
      access(1'b0, 1'b0, 8'h00, 3'(s),
             {8'ha0 + 8'(s), 8'(s * 16 + 1)}, d);
      check("read move data", d, 8'h3c ^ 8'(s));
      access(1'b1, 1'b0, 8'h00, 3'(s), 16'h4000 + 16'(s), d);
      check("fetch data", d, 8'h40 ^ 8'(s) ^ 8'h5a);
    end
    sfr_write(ADDR_PTR_SEL, 8'hff);
    sfr_read(ADDR_PTR_SEL, d);
    check("select bits", d, 8'h01);
    sfr_write(ADDR_PTR1_LO, 8'hff);
    sfr_write(ADDR_PTR1_HI, 8'h12);
    @(posedge clk); #1 inc = 1'b1;
    @(posedge clk); #1 inc = 1'b0;
    sfr_read(ADDR_PTR1_LO, d);
    check("pointer1 low", d, 8'h00);
    sfr_read(ADDR_PTR1_HI, d);
    check("pointer1 high", d, 8'h13);
    sfr_read(ADDR_PTR0_HI, d);
    check("pointer0 high", d, 8'ha7);
    access(1'b0, 1'b1, 8'h99, 3'h7, 16'h1300, d);
    sfr_write(ADDR_PTR_SEL, 8'h00);
    access(1'b0, 1'b0, 8'h00, 3'h7, 16'ha771, d);
    check("pointer0 move data", d, 8'h3b);
    conclude();
  end
endmodule : tb_ext_data_access_stretch_ctrl
`default_nettype wire
